// ===== core/keypad_port.sv
/*
 Normal-mode pin logic of an infrared remote keypad controller: key scan port,
 key return inputs, special inputs, transmit indicator and carrier output,
 controlled over AXI4-Lite. Assumes a 100 MHz clk and pads that resolve
 the enables and pull-down requests into pin levels.
*/
// Notes on behaviour
// - Scan port direction switched as one group
// - Output mode drives scan lines to matrix
// - One bit sets first two special pull-downs
// - Released first special input is off, high-z
// - Indicator low while carrier transmits, else high
// - Carrier widths programmable 250 ns to 64 us
// - Stop release enable adds pull-down, allows wake
// - Release disabled: plain input, never wakes
// - Reset: third input high-z, release disabled
// - One bit sets all key return pull-downs
// - Fourth input has pull-down and off mode
`timescale 1ns/1ps
`default_nettype none
`include "keypad_port_defs.svh"
module keypad_port (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // AXI4-Lite write address and data
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Key scan lines
  input wire logic [7:0] key_scan_io_lines_in,
  output logic [7:0] key_scan_io_lines_out,
  output logic key_scan_io_lines_oe_n,
  output logic key_scan_pulldown,
  // Key return inputs
  input wire logic [3:0] key_return_inputs,
  output logic key_return_pulldown,
  // Special inputs
  input wire logic first_special_input,
  output logic first_special_enable,
  output logic first_second_pulldown,
  input wire logic second_input_or_tx_indicator_in,
  output logic second_input_or_tx_indicator_out,
  output logic second_input_or_tx_indicator_oe_n,
  input wire logic stop_release_input,
  output logic stop_release_pulldown,
  output logic stop_wake,
  input wire logic fourth_special_input,
  output logic fourth_special_enable,
  output logic fourth_special_pulldown,
  // Carrier
  output logic ir_carrier_output
);
  logic [7:0] port_ctrl;
  logic [7:0] scan_out;
  logic [7:0] carrier_high;
  logic [7:0] carrier_low;
  logic carrier_en;
  logic [7:0] scan_meta;
  logic [7:0] scan_sync;
  logic [7:0] pins_meta;
  logic [7:0] pins_sync;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic have_aw;
  logic have_w;
  logic do_write;
  carrier_if car ();

  //////////////////////////////////////////////////////////////////////////////
  // Register bus

  function automatic logic mapped(input logic [11:0] a);
    mapped = a == `OFS_PORT_CTRL || a == `OFS_SCAN_OUT || a == `OFS_CARRIER_HIGH ||
      a == `OFS_CARRIER_LOW || a == `OFS_CARRIER_CTRL || a == `OFS_PIN_STATUS;
  endfunction : mapped

  // Address and data may arrive in either order; each is held until both are in
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      have_aw <= 1'b0;
      wr_addr <= 12'h000;
    end else if (do_write) begin
      have_aw <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      have_aw <= 1'b1;
      wr_addr <= {s_axi_awaddr[11:2], 2'b00};
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      have_w <= 1'b0;
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
    end else if (do_write) begin
      have_w <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      have_w <= 1'b1;
      wr_data <= s_axi_wdata;
      wr_strb <= s_axi_wstrb;
    end
  end

  assign do_write = have_aw && have_w && !s_axi_bvalid;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !have_aw && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !have_w && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= keypad_port_pkg::resp_okay;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= mapped(wr_addr) ? keypad_port_pkg::resp_okay :
        keypad_port_pkg::resp_slverr;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Only byte lane 0 carries data; writes without it change nothing
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      port_ctrl <= `PORT_CTRL_RESET;
      scan_out <= `SCAN_OUT_RESET;
      carrier_high <= `CARRIER_WIDTH_RESET;
      carrier_low <= `CARRIER_WIDTH_RESET;
      carrier_en <= 1'b0;
    end else if (do_write && wr_strb[0]) begin
      unique case (wr_addr)
        `OFS_PORT_CTRL: port_ctrl <= wr_data[7:0];
        `OFS_SCAN_OUT: scan_out <= wr_data[7:0];
        `OFS_CARRIER_HIGH: carrier_high <= wr_data[7:0];
        `OFS_CARRIER_LOW: carrier_low <= wr_data[7:0];
        `OFS_CARRIER_CTRL: carrier_en <= wr_data[0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= keypad_port_pkg::resp_okay;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      s_axi_arready <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= mapped({s_axi_araddr[11:2], 2'b00}) ? keypad_port_pkg::resp_okay :
        keypad_port_pkg::resp_slverr;
      unique case ({s_axi_araddr[11:2], 2'b00})
        `OFS_PORT_CTRL: s_axi_rdata <= {24'h000000, port_ctrl};
        `OFS_SCAN_OUT: s_axi_rdata <= {24'h000000, scan_sync};
        `OFS_CARRIER_HIGH: s_axi_rdata <= {24'h000000, carrier_high};
        `OFS_CARRIER_LOW: s_axi_rdata <= {24'h000000, carrier_low};
        `OFS_CARRIER_CTRL: s_axi_rdata <= {30'h0, car.active, carrier_en};
        `OFS_PIN_STATUS: s_axi_rdata <= {24'h000000, pins_sync};
        default: s_axi_rdata <= 32'h00000000;
      endcase
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisers; no logic reads a pin before the second stage

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      scan_meta <= 8'h00;
      scan_sync <= 8'h00;
      pins_meta <= 8'h00;
      pins_sync <= 8'h00;
    end else begin
      scan_meta <= key_scan_io_lines_in;
      scan_sync <= scan_meta;
      pins_meta <= {key_return_inputs, fourth_special_input, stop_release_input,
        second_input_or_tx_indicator_in, first_special_input};
      pins_sync <= pins_meta;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Carrier

  assign car.enable = carrier_en;
  assign car.high_steps = carrier_high;
  assign car.low_steps = carrier_low;

  carrier_gen u_carrier (
    .clk(clk),
    .reset_n(reset_n),
    .car(car)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Pin control, all outputs registered

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      key_scan_io_lines_oe_n <= 1'b0;
      key_scan_io_lines_out <= `SCAN_OUT_RESET;
      key_scan_pulldown <= 1'b0;
    end else begin
      key_scan_io_lines_oe_n <= !port_ctrl[`BIT_SCAN_OUTPUT];
      key_scan_io_lines_out <= scan_out;
      key_scan_pulldown <= !port_ctrl[`BIT_SCAN_OUTPUT];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      first_special_enable <= 1'b0;
      first_second_pulldown <= 1'b0;
      key_return_pulldown <= 1'b0;
      fourth_special_enable <= 1'b0;
      fourth_special_pulldown <= 1'b0;
    end else begin
      first_special_enable <= port_ctrl[`BIT_S0_INPUT];
      first_second_pulldown <= port_ctrl[`BIT_S01_PULLDOWN];
      key_return_pulldown <= port_ctrl[`BIT_KEY_RET_PULLDOWN];
      fourth_special_enable <= port_ctrl[`BIT_S3_INPUT];
      fourth_special_pulldown <= port_ctrl[`BIT_S3_INPUT] &&
        port_ctrl[`BIT_S3_PULLDOWN];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      second_input_or_tx_indicator_oe_n <= 1'b0;
      second_input_or_tx_indicator_out <= 1'b1;
      ir_carrier_output <= 1'b0;
    end else begin
      second_input_or_tx_indicator_oe_n <= !port_ctrl[`BIT_SECOND_INPUT_OR_TX_INDICATOR_MODE];
      second_input_or_tx_indicator_out <= !car.active;
      ir_carrier_output <= car.level;
    end
  end

  // Wake needs both the enable and a high level on the synchronised pin
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      stop_release_pulldown <= 1'b0;
      stop_wake <= 1'b0;
    end else begin
      stop_release_pulldown <= port_ctrl[`BIT_STOP_RELEASE_EN];
      stop_wake <= port_ctrl[`BIT_STOP_RELEASE_EN] && pins_sync[2];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  a_scan_direction: assert property (@(posedge clk) disable iff (!reset_n)
    key_scan_io_lines_oe_n == key_scan_pulldown)
    else $error("scan pull-down not tied to input mode");
  a_scan_drive: assert property (@(posedge clk) disable iff (!reset_n)
    $changed(scan_out) |=> key_scan_io_lines_out == $past(scan_out))
    else $error("scan lines not driven from register");
  a_pair_pulldown: assert property (@(posedge clk) disable iff (!reset_n)
    do_write && wr_strb[0] && wr_addr == `OFS_PORT_CTRL |=>
    ##1 first_second_pulldown == $past(wr_data[`BIT_S01_PULLDOWN], 2))
    else $error("pair pull-down did not follow write");
  a_first_off: assert property (@(posedge clk) disable iff (!reset_n)
    !port_ctrl[`BIT_S0_INPUT] |=> !first_special_enable)
    else $error("first input not off");
  a_indicator_tx: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(ir_carrier_output) |-> !second_input_or_tx_indicator_out)
    else $error("indicator not low while carrier runs");
  a_wake_gate: assert property (@(posedge clk) disable iff (!reset_n)
    stop_wake |-> $past(port_ctrl[`BIT_STOP_RELEASE_EN]) && stop_release_pulldown)
    else $error("wake without release enable");
  a_return_pulldown: assert property (@(posedge clk) disable iff (!reset_n)
    $changed(port_ctrl[`BIT_KEY_RET_PULLDOWN]) |=>
    key_return_pulldown == $past(port_ctrl[`BIT_KEY_RET_PULLDOWN]))
    else $error("return pull-down lagging");
  a_fourth_off: assert property (@(posedge clk) disable iff (!reset_n)
    fourth_special_pulldown |-> fourth_special_enable)
    else $error("pull-down on off-mode fourth input");
endmodule : keypad_port
`default_nettype wire

// ===== core/keypad_port_defs.svh
/*
 Timing counts, field positions and reset values for the keypad port block.
 Assumes a 100 MHz core clock; included by bare name.
*/
`ifndef KEYPAD_PORT_DEFS_SVH
`define KEYPAD_PORT_DEFS_SVH

// Register byte offsets
`define OFS_PORT_CTRL 12'h000
`define OFS_SCAN_OUT 12'h004
`define OFS_CARRIER_HIGH 12'h008
`define OFS_CARRIER_LOW 12'h00C
`define OFS_CARRIER_CTRL 12'h010
`define OFS_PIN_STATUS 12'h014

// Port control fields
`define BIT_SCAN_OUTPUT 0
`define BIT_S01_PULLDOWN 1
`define BIT_S0_INPUT 2
`define BIT_SECOND_INPUT_OR_TX_INDICATOR_MODE 3
`define BIT_STOP_RELEASE_EN 4
`define BIT_KEY_RET_PULLDOWN 5
`define BIT_S3_INPUT 6
`define BIT_S3_PULLDOWN 7
`define PORT_CTRL_RESET 8'h09

`define SCAN_OUT_RESET 8'hFF

// Carrier widths: 250 ns step, 64 us maximum, 256 steps
`define CARRIER_STEP_NS 250
`define CLK_PERIOD_NS 10
`define CARRIER_STEP_CYCLES (`CARRIER_STEP_NS / `CLK_PERIOD_NS)
`define CARRIER_WIDTH_RESET 8'h00

`endif

// ===== core/keypad_port_pkg.sv
/*
 Types shared by the keypad port block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package keypad_port_pkg;
  typedef enum logic [1:0] {
    resp_okay = 2'b00,
    resp_slverr = 2'b10
  } axi_resp_t;
  typedef enum {
    car_idle,
    car_high,
    car_low
  } carrier_state_t;
endpackage : keypad_port_pkg

// ===== core/carrier_if.sv
/*
 Carrier timing bundle between the port top and the carrier generator.
 Assumes one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
interface carrier_if;
  logic enable;
  logic [7:0] high_steps;
  logic [7:0] low_steps;
  logic level;
  logic active;
  modport ctrl (output enable, output high_steps, output low_steps, input level, input active);
  modport gen (input enable, input high_steps, input low_steps, output level, output active);
endinterface : carrier_if
`default_nettype wire

// ===== core/carrier_gen.sv
/*
 Carrier generator: alternating high and low phases, each (n+1) x 250 ns.
 Assumes widths are stable while enabled; new values apply at the next phase.
*/
`timescale 1ns/1ps
`default_nettype none
`include "keypad_port_defs.svh"
module carrier_gen (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Timing and output
  carrier_if.gen car
);
  keypad_port_pkg::carrier_state_t state;
  logic [4:0] tick;
  logic [7:0] steps;
  logic step_done;

  assign step_done = (tick == 5'(`CARRIER_STEP_CYCLES - 1));

  always_ff @(posedge clk) begin
    if (!reset_n || state == keypad_port_pkg::car_idle || step_done) begin
      tick <= 5'h00;
    end else begin
      tick <= tick + 5'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n || !car.enable) begin
      state <= keypad_port_pkg::car_idle;
      steps <= 8'h00;
    end else begin
      unique case (state)
        keypad_port_pkg::car_idle: begin
          state <= keypad_port_pkg::car_high;
          steps <= car.high_steps;
        end
        keypad_port_pkg::car_high: begin
          if (step_done) begin
            if (steps == 8'h00) begin
              state <= keypad_port_pkg::car_low;
              steps <= car.low_steps;
            end else begin
              steps <= steps - 8'h01;
            end
          end
        end
        keypad_port_pkg::car_low: begin
          if (step_done) begin
            if (steps == 8'h00) begin
              state <= keypad_port_pkg::car_high;
              steps <= car.high_steps;
            end else begin
              steps <= steps - 8'h01;
            end
          end
        end
      endcase
    end
  end

  assign car.level = (state == keypad_port_pkg::car_high);
  assign car.active = (state != keypad_port_pkg::car_idle);

  // Length of the running high phase; a long repetition in the property
  // itself would be unrolled by the tools, so the cycles are counted here
  logic [12:0] high_len;

  always_ff @(posedge clk) begin
    if (!reset_n || !car.level) begin
      high_len <= 13'h0;
    end else begin
      high_len <= high_len + 13'h1;
    end
  end

  a_high_width: assert property (@(posedge clk) disable iff (!reset_n)
    $fell(car.level) && car.enable |->
    32'(high_len) == (32'(car.high_steps) + 32'h1) * `CARRIER_STEP_CYCLES)
    else $error("carrier high phase width wrong");
endmodule : carrier_gen
`default_nettype wire

// ===== dv/keypad_far_side.sv
/*
 Far side of the keypad port: key matrix, indicator LED and pin pull-downs.
 Assumes the design's pin enables arrive unresolved; lines are resolved here.
*/
`timescale 1ns/1ps
`default_nettype none
module keypad_far_side (
  // Clock
  input wire logic clk,
  // Scan port
  input wire logic [7:0] scan_out,
  input wire logic scan_oe_n,
  input wire logic scan_pd,
  output logic [7:0] scan_pin,
  // Key i closes scan line i/4 onto return line i%4
  input wire logic [31:0] pressed,
  input wire logic ret_pd,
  output logic [3:0] ret_pin,
  // Indicator
  input wire logic led_out,
  input wire logic led_oe_n,
  output logic led_lit
);
  logic tog = 1'h0;
  // Floating lines wander so a missing pull-down is never hidden
  always @(posedge clk) tog <= !tog;
  always_comb begin
    scan_pin = scan_oe_n ? (scan_pd ? 8'h00 : {8{tog}}) : scan_out;
    for (int j = 0; j < 4; j++) begin
      ret_pin[j] = ret_pd ? 1'h0 : tog;
      for (int i = 0; i < 8; i++) begin
        if (pressed[i*4+j] && scan_pin[i]) ret_pin[j] = 1'h1;
      end
    end
  end
  assign led_lit = !led_oe_n && !led_out;
endmodule : keypad_far_side
`default_nettype wire

// ===== dv/remote_keypad_port_pins_tb.sv
/*
 Self-checking bench for the keypad port: AXI4-Lite driver, read/response
 queue with a monitor, pin control, matrix, wake and carrier scenarios.
 Assumes the design's register map and reset values from its header.
*/
`timescale 1ns/1ps
`default_nettype none
`include "keypad_port_defs.svh"
module remote_keypad_port_pins_tb;
  logic clk = 1'h0;
  logic reset_n = 1'h0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [7:0] key_scan_io_lines_in, key_scan_io_lines_out;
  logic key_scan_io_lines_oe_n, key_scan_pulldown, key_return_pulldown;
  logic [3:0] key_return_inputs;
  logic first_special_input = '0, second_input_or_tx_indicator_in = '0;
  logic stop_release_input = '0, fourth_special_input = '0;
  logic first_special_enable, first_second_pulldown, second_input_or_tx_indicator_out;
  logic second_input_or_tx_indicator_oe_n, stop_release_pulldown, stop_wake;
  logic fourth_special_enable, fourth_special_pulldown, ir_carrier_output, led_lit;
  logic [31:0] pressed = '0, p;
  logic [7:0] c, s, h, l;
  logic [3:0] r, sp;
  logic [33:0] exp_q[$];
  int error_cnt = 0, check_count = 0, i, n, k;
  wire logic [8:0] pin_ctl = {key_scan_io_lines_oe_n, key_scan_pulldown,
    first_second_pulldown, first_special_enable, second_input_or_tx_indicator_oe_n,
    stop_release_pulldown, key_return_pulldown, fourth_special_enable,
    fourth_special_pulldown};

  keypad_port dut (.*);
  keypad_far_side far (.clk(clk), .scan_out(key_scan_io_lines_out),
    .scan_oe_n(key_scan_io_lines_oe_n), .scan_pd(key_scan_pulldown),
    .scan_pin(key_scan_io_lines_in), .pressed(pressed), .ret_pd(key_return_pulldown),
    .ret_pin(key_return_inputs), .led_out(second_input_or_tx_indicator_out),
    .led_oe_n(second_input_or_tx_indicator_oe_n), .led_lit(led_lit));

  always #5 clk = !clk;
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [33:0] e, input logic [33:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic results;
    if (error_cnt == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results

  // Monitor: each response on the bus retires the oldest note
  always @(posedge clk) begin
    if (s_axi_rvalid && s_axi_rready) chk("rdata", exp_q.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready) chk("bresp", exp_q.pop_front(), {s_axi_bresp, 32'h0});
  end

  // Waits for the answer as long as it takes; only the watchdog ends a hang
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] rs);
    exp_q.push_back({rs, 32'h0});
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!s_axi_bvalid) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end
    s_axi_bready <= 1'h0;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!s_axi_rvalid) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end
    s_axi_rready <= 1'h0;
  endtask : rd

  // The fourth pull-down only applies while that input is in input mode
  function automatic logic [8:0] pins_for(input logic [7:0] v);
    return {!v[0], !v[0], v[1], v[2], !v[3], v[4], v[5], v[6], v[6] && v[7]};
  endfunction : pins_for

  // Counts whole cycles while the carrier holds level v
  task automatic span(input logic v, output int cnt);
    for (cnt = 0; cnt < 9000 && ir_carrier_output === v; cnt++) begin
      @(posedge clk);
      #1;
    end
  endtask : span
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #300_000;
    error_cnt++;
    results();
  end

  initial begin
    void'($urandom(32'h4CB5));
    repeat (8) @(posedge clk);
    reset_n <= 1'h1;
    #1;
    chk("pin_ctl", pins_for(`PORT_CTRL_RESET), pin_ctl);
    chk("outs", {8'hFF, 3'h4}, {key_scan_io_lines_out, second_input_or_tx_indicator_out,
      ir_carrier_output, stop_wake});
    rd(`OFS_PORT_CTRL, {26'h0, `PORT_CTRL_RESET});
    rd(`OFS_SCAN_OUT, {26'h0, `SCAN_OUT_RESET});
    for (i = 0; i < 12; i++) begin
      c = (i < 8) ? 8'h01 << i : 8'($urandom);
      wr(`OFS_PORT_CTRL, {24'h0, c}, 2'h0);
      #1;
      chk("pin_ctl", pins_for(c), pin_ctl);
      rd(`OFS_PORT_CTRL, {26'h0, c});
    end
    for (i = 0; i < 6; i++) begin
      c = i[0] ? 8'h75 : 8'h65;
      s = 8'($urandom);
      p = $urandom;
      sp = 4'($urandom) | 4'h4;
      pressed <= p;
      {fourth_special_input, stop_release_input, second_input_or_tx_indicator_in,
        first_special_input} <= sp;
      wr(`OFS_PORT_CTRL, {24'h0, c}, 2'h0);
      wr(`OFS_SCAN_OUT, {24'h0, s}, 2'h0);
      #1;
      chk("scan_out", s, key_scan_io_lines_out);
      r = '0;
      for (k = 0; k < 32; k++) if (p[k] && s[k/4]) r[k%4] = 1'h1;
      repeat (3) @(posedge clk);
      #1;
      chk("stop_wake", c[4], stop_wake);
      rd(`OFS_PIN_STATUS, {26'h0, r, sp});
    end
    rd(12'h020, {2'h2, 32'h0});
    wr(12'h018, 32'h5A, 2'h2);
    // A write without byte lane 0 is answered but changes nothing
    s_axi_wstrb <= 4'hE;
    wr(`OFS_PORT_CTRL, 32'h0, 2'h0);
    s_axi_wstrb <= 4'hF;
    rd(`OFS_PORT_CTRL, {26'h0, c});
    for (i = 0; i < 2; i++) begin
      h = i ? 8'hFF : 8'h00;
      l = i ? 8'h00 : 8'h01;
      wr(`OFS_PORT_CTRL, 32'h09, 2'h0);
      wr(`OFS_CARRIER_HIGH, {24'h0, h}, 2'h0);
      wr(`OFS_CARRIER_LOW, {24'h0, l}, 2'h0);
      wr(`OFS_CARRIER_CTRL, 32'h1, 2'h0);
      rd(`OFS_CARRIER_CTRL, {32'h3});
      span(1'h0, n);
      span(1'h1, n);
      span(1'h0, n);
      chk("led_high", 1'h1, led_lit);
      span(1'h1, n);
      chk("high_width", (h + 1) * `CARRIER_STEP_CYCLES, n);
      chk("led_low", 1'h1, led_lit);
      span(1'h0, n);
      chk("low_width", (l + 1) * `CARRIER_STEP_CYCLES, n);
      wr(`OFS_CARRIER_CTRL, 32'h0, 2'h0);
      for (n = 0; n < 9000 && !second_input_or_tx_indicator_out; n++) @(negedge clk);
      chk("idle", 2'h2, {second_input_or_tx_indicator_out, ir_carrier_output});
    end
    results();
  end
endmodule : remote_keypad_port_pins_tb
`default_nettype wire
